//--- src/hw_int_divider_32.sv
// memory-mapped 32-bit integer divider with apb register access
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "int_divider_cfg.svh"
module hw_int_divider_32 #(
  parameter int CYCLES = `DIV_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire int_divider_pkg::word_t pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output int_divider_pkg::word_t    prdata,
  output logic                      pslverr,
  output logic                      irq,
  output logic                      busy
);
  import int_divider_pkg::*;

  // run cycles retire two quotient bits each; the publish cycle retires the last pair
  localparam logic [4:0] LAST_RUN = 5'(CYCLES - 2);

  typedef struct packed {
    logic       int_en;
    logic       unsigned_sel;
    logic       done;
    logic       zero_div;
    word_t      dividend;
    word_t      divisor;
    word_t      quotient;
    word_t      remainder;
    div_state_t state;
    logic [4:0] count;
    logic       neg_q;
    logic       neg_r;
    word_t      work_rem;
    word_t      work_quo;
    word_t      work_dvs;
    logic       pready;
    word_t      prdata;
    logic       pslverr;
    logic       irq;
    logic       busy;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  logic  setup;
  logic  wr;
  logic  rd;
  logic  mapped;
  logic  in_signed;
  word_t abs_dividend;
  word_t abs_divisor;
  word_t rem_mid;
  word_t quo_mid;
  word_t rem_step;
  word_t quo_step;
  word_t quo_fixed;
  word_t rem_fixed;
  logic  sel_config;
  logic  sel_status;
  logic  sel_dividend;
  logic  sel_divisor;
  logic  sel_quotient;
  logic  sel_remainder;
  logic  start_div;
  logic  start_zero;
  logic  clear_done;
  logic  clear_zero;
  logic  last_run;
  word_t config_word;
  word_t status_word;
  word_t read_word;

  // operand magnitudes for signed mode
  assign in_signed = ~r_q.unsigned_sel;

  sign_fix #(.W(32)) u_abs_dividend (
    .value  (r_q.dividend),
    .negate (in_signed & r_q.dividend[31]),
    .result (abs_dividend)
  );

  sign_fix #(.W(32)) u_abs_divisor (
    .value  (pwdata),
    .negate (in_signed & pwdata[31]),
    .result (abs_divisor)
  );

  // two restoring steps per clock give 32 quotient bits in 16 cycles
  div_step #(.W(32)) u_step0 (
    .rem_in  (r_q.work_rem),
    .quo_in  (r_q.work_quo),
    .divisor (r_q.work_dvs),
    .rem_out (rem_mid),
    .quo_out (quo_mid)
  );

  div_step #(.W(32)) u_step1 (
    .rem_in  (rem_mid),
    .quo_in  (quo_mid),
    .divisor (r_q.work_dvs),
    .rem_out (rem_step),
    .quo_out (quo_step)
  );

  sign_fix #(.W(32)) u_fix_quo (
    .value  (quo_step),
    .negate (r_q.neg_q),
    .result (quo_fixed)
  );

  sign_fix #(.W(32)) u_fix_rem (
    .value  (rem_step),
    .negate (r_q.neg_r),
    .result (rem_fixed)
  );

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite & r_q.pready;
  assign rd     = setup & ~pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_REMAINDER_RESULT);

  // register selects; an unaligned or out-of-range offset selects nothing
  assign sel_config    = mapped && (paddr == `OFS_DIVIDER_CONFIG);
  assign sel_status    = mapped && (paddr == `OFS_DIVIDER_STATUS);
  assign sel_dividend  = mapped && (paddr == `OFS_DIVIDEND_OPERAND);
  assign sel_divisor   = mapped && (paddr == `OFS_DIVISOR_OPERAND);
  assign sel_quotient  = mapped && (paddr == `OFS_QUOTIENT_RESULT);
  assign sel_remainder = mapped && (paddr == `OFS_REMAINDER_RESULT);

  // the divisor write launches the operation; a zero divisor raises its flag, clears done and returns to idle
  assign start_div  = wr & sel_divisor & (pwdata != `RESET_WORD);
  assign start_zero = wr & sel_divisor & (pwdata == `RESET_WORD);

  // write-one-to-clear requests on the status flags
  assign clear_done = wr & sel_status & pstrb[0] & pwdata[`STAT_DONE_BIT];
  assign clear_zero = wr & sel_status & pstrb[0] & pwdata[`STAT_ZERO_DIV_BIT];

  // last run cycle; the publish cycle follows it
  assign last_run = (r_q.state == ST_RUN) && (r_q.count == LAST_RUN);

  // narrow registers read back in the low bits, the rest as zero
  assign config_word = {30'h0000_0000, r_q.unsigned_sel, r_q.int_en};
  assign status_word = {30'h0000_0000, r_q.zero_div, r_q.done};

  assign read_word = sel_config    ? config_word :
                     sel_status    ? status_word :
                     sel_dividend  ? r_q.dividend :
                     sel_divisor   ? r_q.divisor :
                     sel_quotient  ? r_q.quotient :
                     sel_remainder ? r_q.remainder :
                     `RESET_WORD;

  always_comb begin
    r_d = r_q;

    // zero wait states: the access cycle after setup always sees pready high
    r_d.pready  = setup;
    r_d.pslverr = setup & ~mapped;
    // read data stands for the access cycle only and is zero otherwise
    r_d.prdata  = rd ? read_word : `RESET_WORD;

    // configuration, both bits in byte lane 0
    if (wr && sel_config && pstrb[0]) begin
      r_d.int_en       = pwdata[`CFG_INT_EN_BIT];
      r_d.unsigned_sel = pwdata[`CFG_UNSIGNED_BIT];
    end

    // dividend, written lane by lane
    if (wr && sel_dividend) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          r_d.dividend[8*b +: 8] = pwdata[8*b +: 8];
        end
      end
    end

    // the divisor always takes the whole word
    if (wr && sel_divisor) begin
      r_d.divisor = pwdata;
    end

    // flag clears come first so that a completion in the same cycle wins
    if (clear_done) begin
      r_d.done = 1'b0;
    end
    if (clear_zero) begin
      r_d.zero_div = 1'b0;
    end

    // divider sequencing
    unique case (r_q.state)
      ST_IDLE: begin
      end
      ST_RUN: begin
        r_d.work_rem = rem_step;
        r_d.work_quo = quo_step;
        r_d.count    = r_q.count + 5'd1;
        if (last_run) begin
          r_d.state = ST_FIX;
        end
      end
      ST_FIX: begin
        // last cycle of 16: retire the final bit pair, apply the signs and raise done
        r_d.quotient  = quo_fixed;
        r_d.remainder = rem_fixed;
        r_d.done      = 1'b1;
        r_d.state     = ST_IDLE;
      end
      default: begin
        // unused encoding: fall back to idle
        r_d.state = ST_IDLE;
      end
    endcase

    // a zero divisor flags at once and leaves the results alone
    if (start_zero) begin
      r_d.done     = 1'b0;
      r_d.zero_div = 1'b1;
      r_d.state    = ST_IDLE;
    end

    if (start_div) begin
      // start with current dividend and sign mode
      r_d.done     = 1'b0;
      r_d.work_rem = `RESET_WORD;
      r_d.work_quo = abs_dividend;
      r_d.work_dvs = abs_divisor;
      r_d.neg_q    = in_signed & (r_q.dividend[31] ^ pwdata[31]);
      r_d.neg_r    = in_signed & r_q.dividend[31];
      r_d.count    = 5'd0;
      r_d.state    = ST_RUN;
    end

    r_d.irq  = r_d.done & r_d.int_en;
    r_d.busy = (r_d.state != ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign pready  = r_q.pready;
  assign prdata  = r_q.prdata;
  assign pslverr = r_q.pslverr;
  assign irq     = r_q.irq;
  assign busy    = r_q.busy;
endmodule
`default_nettype wire

//--- src/int_divider_cfg.svh
// register offsets, field positions, reset values and timing counts of the divider
`ifndef INT_DIVIDER_CFG_SVH
`define INT_DIVIDER_CFG_SVH

`define OFS_DIVIDER_CONFIG   8'h00
`define OFS_DIVIDER_STATUS   8'h04
`define OFS_DIVIDEND_OPERAND 8'h08
`define OFS_DIVISOR_OPERAND  8'h0c
`define OFS_QUOTIENT_RESULT  8'h10
`define OFS_REMAINDER_RESULT 8'h14

`define CFG_INT_EN_BIT       0
`define CFG_UNSIGNED_BIT     1
`define STAT_DONE_BIT        0
`define STAT_ZERO_DIV_BIT    1

`define RESET_WORD           32'h0000_0000
`define DIV_CYCLES           16
`define BITS_PER_CYCLE       2

`endif

//--- src/int_divider_pkg.sv
// types shared by the divider files
`default_nettype none
package int_divider_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_FIX
  } div_state_t;
endpackage
`default_nettype wire

//--- src/div_step.sv
// one restoring division step on an unsigned partial remainder
`timescale 1ns/100ps
`default_nettype none
module div_step #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] rem_in,
  input  wire logic [W-1:0] quo_in,
  input  wire logic [W-1:0] divisor,
  output logic      [W-1:0] rem_out,
  output logic      [W-1:0] quo_out
);
  logic [W:0] shifted;
  logic [W:0] diff;

  always_comb begin
    shifted = {rem_in, quo_in[W-1]};
    diff    = shifted - {1'b0, divisor};
    if (diff[W]) begin
      rem_out = shifted[W-1:0];
      quo_out = {quo_in[W-2:0], 1'b0};
    end else begin
      rem_out = diff[W-1:0];
      quo_out = {quo_in[W-2:0], 1'b1};
    end
  end
endmodule
`default_nettype wire

//--- src/sign_fix.sv
// magnitude/sign conversion for a two's-complement word
`timescale 1ns/100ps
`default_nettype none
module sign_fix #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] value,
  input  wire logic         negate,
  output logic      [W-1:0] result
);
  always_comb begin
    result = negate ? (~value + {{(W-1){1'b0}}, 1'b1}) : value;
  end
endmodule
`default_nettype wire

//--- bench/hw_int_divider_32_monitor.sv
// assertions on the divider's bus and timing behaviour
`timescale 1ns/100ps
`default_nettype none
module hw_int_divider_32_monitor #(
  parameter int CYCLES = 16
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire int_divider_pkg::word_t pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire int_divider_pkg::word_t prdata,
  input wire logic                   pslverr,
  input wire logic                   irq,
  input wire logic                   busy
);
  import int_divider_pkg::*;
  logic acc;
  logic wr;
  logic rd;
  logic cfg_wr;
  assign acc = psel & penable & pready;
  assign cfg_wr = acc & pwrite & (paddr == 8'h00);
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_start; wr && paddr == 8'h0c && pwdata != 32'h0000_0000 |=> busy; endproperty
  a_start: assert property (p_start) else $error("divisor write did not start");
  property p_len; $rose(busy) |-> ##15 busy ##1 !busy; endproperty
  a_len: assert property (p_len) else $error("division length wrong");
  property p_zero; wr && paddr == 8'h0c && pwdata == 32'h0000_0000 |=> !busy; endproperty
  a_zero: assert property (p_zero) else $error("zero divisor ran");
  property p_stat; rd && busy && paddr == 8'h04 |-> !prdata[0]; endproperty
  a_stat: assert property (p_stat) else $error("done seen while running");
  property p_busyirq; busy |-> !irq; endproperty
  a_busyirq: assert property (p_busyirq) else $error("irq while running");
  property p_irqup; $rose(irq) |-> $past(busy) || $past(cfg_wr); endproperty
  a_irqup: assert property (p_irqup) else $error("irq rose without cause");
  property p_irqdn; $fell(irq) |-> $past(wr); endproperty
  a_irqdn: assert property (p_irqdn) else $error("irq fell without write");
  property p_cfg; rd && paddr == 8'h00 |-> prdata[31:2] == 30'h0000_0000; endproperty
  a_cfg: assert property (p_cfg) else $error("config upper bits set");
  property p_map; acc && paddr > 8'h14 |-> pslverr; endproperty
  a_map: assert property (p_map) else $error("unmapped access accepted");
  c_done: cover property ($fell(busy));
  c_zero: cover property (wr && paddr == 8'h0c && pwdata == 32'h0000_0000);
  c_err: cover property (acc && pslverr);
endmodule
bind hw_int_divider_32 hw_int_divider_32_monitor #(.CYCLES(CYCLES)) hw_int_divider_32_monitor_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .busy(busy));
`default_nettype wire

//--- bench/hw_int_divider_32_bench.sv
// self-checking bench for the divider
`timescale 1ns/100ps
`default_nettype none
module hw_int_divider_32_bench;
  import int_divider_pkg::*;
  logic       pclk;
  logic       presetn = 1'b0;
  logic       psel = 1'b0;
  logic       penable = 1'b0;
  logic       pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'hf;
  word_t      pwdata = 32'h0000_0000;
  word_t      prdata, rv, q, r;
  logic       pready, pslverr, irq, busy, ev;
  int         bad_count, checks_done, n;
  int         cyc = 0;
  hw_int_divider_32 hw_int_divider_32_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq), .busy(busy));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk; // free-running 50 ns bench clock
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      conclude;
    end
  end
  task chk(input word_t got, input word_t exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; one idle cycle before each setup, answer taken at the edge that sees pready
  task xfer(input logic w, input logic [7:0] a, input word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_regs;
    for (int a = 0; a < 24; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0000_0000);
      chk(rv, 32'h0000_0000);
    end
    xfer(1'b1, 8'h00, 32'hffff_ffff);
    xfer(1'b0, 8'h00, 32'h0000_0000);
    chk(rv, 32'h0000_0003);
    xfer(1'b0, 8'h18, 32'h0000_0000);
    chk(32'(ev), 32'h0000_0001);
    pstrb <= 4'h3;
    xfer(1'b1, 8'h08, 32'hffff_ffff);
    pstrb <= 4'hf;
    xfer(1'b0, 8'h08, 32'h0000_0000);
    chk(rv, 32'h0000_ffff);
  endtask
  task t_div(input logic u, input logic ie, input word_t a, input word_t b);
    xfer(1'b1, 8'h00, {30'h0000_0000, u, ie});
    xfer(1'b1, 8'h08, a);
    xfer(1'b1, 8'h0c, b);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rv, (b != 0) ? 32'h0000_0000 : 32'h0000_0002);
    n = 0;
    while (busy === 1'b1) begin
      n++;
      @(posedge pclk);
    end
    // the status read covered the first two edges that sample busy high
    chk(n, (b != 0) ? 16 - 2 : 0);
    if (b != 0) begin
      if (u) begin
        q = a / b;
        r = a % b;
      end else begin
        q = $signed(a) / $signed(b);
        r = $signed(a) % $signed(b);
      end
    end
    chk(32'(irq), 32'(ie && b != 0));
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk(rv, q);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    chk(rv, r);
    xfer(1'b1, 8'h04, 32'h0000_0000);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rv, (b != 0) ? 32'h0000_0001 : 32'h0000_0002);
    xfer(1'b1, 8'h04, 32'h0000_0003);
    xfer(1'b0, 8'h04, 32'h0000_0000);
    chk(rv | 32'(irq), 32'h0000_0000);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    q = 32'h0000_0000;
    r = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_div(1'b0, 1'b1, 32'h0000_0064, 32'h0000_0003);
    t_div(1'b0, 1'b0, 32'h0000_0064, 32'hffff_fffd);
    t_div(1'b0, 1'b1, 32'hffff_ff9c, 32'h0000_0003);
    t_div(1'b0, 1'b1, 32'hffff_ff9c, 32'hffff_fffd);
    t_div(1'b0, 1'b1, 32'h0000_0005, 32'h0000_0000);
    t_div(1'b1, 1'b1, 32'hffff_ff9c, 32'h0000_0003);
    t_div(1'b1, 1'b0, 32'h0000_0007, 32'h8000_0000);
    conclude;
  end
endmodule
`default_nettype wire
